// *** gdpg_pkg.sv ***
// Shared constants and carrier types for the gaussian double pulse generator
`default_nettype none
package gdpg_pkg;
  localparam int unsigned CLK_MHZ        = 100;
  localparam int unsigned STEP_NS        = 50;
  localparam int unsigned STEP_CYC       = STEP_NS * CLK_MHZ / 1000;
  localparam int unsigned MARK_NS        = 400;
  localparam int unsigned MARK_CYC       = (MARK_NS * CLK_MHZ + 999) / 1000;
  // Limits in 0.05 us steps; rate limits in pairs per second
  localparam logic [11:0] WIDTH_MIN      = 12'h032;
  localparam logic [11:0] WIDTH_MAX      = 12'h0a0;
  localparam logic [11:0] RISE_MIN       = 12'h010;
  localparam logic [11:0] RISE_MAX       = 12'h073;
  localparam logic [11:0] FALL_MIN       = 12'h01e;
  localparam logic [11:0] FALL_MAX       = 12'h073;
  localparam logic [11:0] SPACE_MIN      = 12'h0b4;
  localparam logic [11:0] SPACE_MAX      = 12'h384;
  localparam logic [15:0] RATE_MIN       = 16'h000a;
  localparam logic [15:0] RATE_MAX       = 16'h1770;
  // Steps per second
  localparam int unsigned STEPS_PER_SEC  = 20000000;
  // Register byte addresses
  localparam logic [7:0]  ADDR_CTRL      = 8'h00;
  localparam logic [7:0]  ADDR_WIDTH     = 8'h04;
  localparam logic [7:0]  ADDR_RISE      = 8'h08;
  localparam logic [7:0]  ADDR_FALL      = 8'h0c;
  localparam logic [7:0]  ADDR_SPACE     = 8'h10;
  localparam logic [7:0]  ADDR_RATE      = 8'h14;
  localparam logic [7:0]  ADDR_STATUS    = 8'h18;
  // Reset values
  localparam logic [11:0] WIDTH_RST      = 12'h046;
  localparam logic [11:0] RISE_RST       = 12'h032;
  localparam logic [11:0] FALL_RST       = 12'h032;
  localparam logic [11:0] SPACE_RST      = 12'h0f0;
  localparam logic [15:0] RATE_RST       = 16'h1770;
  localparam int unsigned AMP_W          = 8;

  typedef struct packed {
    logic        trigMode;
    logic        enable;
    logic [11:0] width;
    logic [11:0] rise;
    logic [11:0] fall;
    logic [11:0] space;
    logic [15:0] rate;
  } gdpg_cfg_t;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_RISE  = 5'h02,
    ST_FLAT  = 5'h04,
    ST_FALL  = 5'h08,
    ST_GAP   = 5'h10
  } gdpg_state_t;
endpackage
`default_nettype wire

// *** gdpg_gen.sv ***
// Gaussian double pulse generator with APB register slave
//
// What this block does
// (R1) Each event is a pair of gaussian-shaped pulses, not rectangles.
// (R2) Continuous and triggered modes; all parameters stay adjustable in both.
// (R3) Pulse width programmable from 2.50 us to 8.00 us.
// (R4) Rise time programmable 0.80 us to 5.75 us, independent of width.
// (R5) Fall time programmable 1.50 us to 5.75 us.
// (R6) Pair spacing programmable 9.00 us to 45.00 us.
// (R7) All times, repetition period included, step in 0.05 us units.
// (R8) Rise and fall measured between 10% and 90% amplitude.
// (R9) Width measured between the two half-amplitude points.
// (R10) Gaussian rise and fall derived from chosen width.
// (R11) Curve in discrete steps; edge done within one step of end.
// (R12) Marker timed from that same one-step completion criterion.
// (R13) One marker per pair, at start of first pulse.
// (R14) Marker held active 400 ns.
// (R15) Outside source drives a logic-level trigger pulse.
// (R16) Shape output kept time-aligned with the RF pulse.
// (R17) Repetition rate given in pulse pairs per second.
// (R18) Illegal width/rise/fall/spacing disables outputs and flags error.
// (R19) Restore-gaussian recomputes edges from width and re-enables output.
// (R20) Continuous: a pair each period; triggered: one per trigger edge, edges during a running pair ignored.
// (R21) Second pulse starts one spacing after start of the first.
//
// The address map and register access over APB are this design's own decisions.
`default_nettype none
module gdpg_gen #(
  parameter int unsigned AMP_W = gdpg_pkg::AMP_W
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  // APB slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  // Trigger and outputs
  input  wire logic             trigIn,
  output logic      [AMP_W-1:0] video,
  output logic                  sync,
  output logic                  profileErr
);
  localparam logic [AMP_W-1:0] AMP_TOP = {AMP_W{1'b1}};

  typedef struct packed {
    gdpg_pkg::gdpg_cfg_t   cfg;
    gdpg_pkg::gdpg_state_t st;
    logic                  second;
    logic [11:0]           phase;
    logic [31:0]           periodCnt;
    logic [11:0]           spaceCnt;
    logic                  spaceRun;
    logic [7:0]            stepDiv;
    logic [7:0]            markCnt;
    logic [7:0]            syncLen;
    logic                  trigPrev;
    logic [AMP_W-1:0]      amp;
    logic [31:0]           rdata;
  } gdpg_reg_t;

  gdpg_reg_t r;
  gdpg_reg_t next_r;

  // Smooth-step approximation of a gaussian edge over x in 0..n
  function automatic logic [AMP_W-1:0] edgeAmp(
    input logic [11:0] x,
    input logic [11:0] n
  );
    logic [23:0] num;
    logic [23:0] f;
    logic [31:0] s;
    num = {4'h0, x, 8'h00};
    f   = (n == 12'h000) ? 24'h0000ff : num / {12'h000, n};
    if (f > 24'h0000ff)
      f = 24'h0000ff;
    // 3f^2 - 2f^3 over 8-bit f gives a bell-like S curve
    s = (32'(f) * 32'(f) * (32'h000002fd - 32'(f) * 32'h2)) >> 16;
    edgeAmp = s[7:0];
  endfunction

  function automatic logic inRange(
    input logic [11:0] v,
    input logic [11:0] lo,
    input logic [11:0] hi
  );
    inRange = (v >= lo) && (v <= hi);
  endfunction

  logic        stepTick;
  logic        legal;
  logic [31:0] periodSteps;
  logic        trigEdge;
  logic        startPair;
  logic [12:0] edgeSum;
  logic [13:0] pulseSum;
  logic [11:0] gaussEdge;
  logic [11:0] halfWidth;
  logic [11:0] gaussFall;
  logic [11:0] gaussRise;
  logic        apbWr;

  assign stepTick    = (r.stepDiv == 8'(gdpg_pkg::STEP_CYC - 1));
  assign edgeSum     = {1'b0, r.cfg.rise} + {1'b0, r.cfg.fall};
  assign pulseSum    = {1'b0, edgeSum} + {2'b00, r.cfg.width};
  // Width/rise/fall/spacing consistency gates the outputs [R18]
  assign legal       = ({1'b0, r.cfg.width} >= edgeSum)
                    && (pulseSum <= {2'b00, r.cfg.space});
  // Pairs per second become a period in 0.05 us steps [R17] [R7]
  assign periodSteps = (r.cfg.rate == 16'h0000) ? 32'hffffffff
                     : 32'(gdpg_pkg::STEPS_PER_SEC) / {16'h0, r.cfg.rate};
  assign trigEdge    = trigIn && !r.trigPrev; // [R15]
  // For a gaussian, t10-90 is about 0.64 of the 50% width [R10]
  assign gaussEdge   = 12'((32'(r.cfg.width) * 32'd164) >> 8);
  // Restored edges are capped so that rise plus fall never exceeds the
  // width; a pure 0.64 ratio would leave the profile illegal [R19] [R18]
  assign halfWidth   = r.cfg.width >> 1;
  assign gaussFall   = (gaussEdge <= halfWidth) ? gaussEdge
                     : (halfWidth >= gdpg_pkg::FALL_MIN) ? halfWidth
                     : gdpg_pkg::FALL_MIN;
  assign gaussRise   = (gaussEdge <= r.cfg.width - gaussFall) ? gaussEdge
                     : r.cfg.width - gaussFall;
  assign apbWr       = psel && penable && pwrite;

  always_comb
  begin
    next_r = r;
    next_r.trigPrev = trigIn;
    next_r.stepDiv  = stepTick ? 8'h00 : r.stepDiv + 8'h01;
    startPair = 1'b0;
    // Pair start: period in continuous mode, one per edge while idle triggered [R20]
    if (r.cfg.trigMode)
      startPair = trigEdge && (r.st == gdpg_pkg::ST_IDLE) && !r.spaceRun;
    else if (stepTick)
      startPair = (r.periodCnt == 32'h0) && !r.spaceRun;
    if (stepTick && !r.cfg.trigMode)
      next_r.periodCnt = (r.periodCnt == 32'h0) ? periodSteps - 32'h1
                                                : r.periodCnt - 32'h1;
    if (r.markCnt != 8'h00)
      next_r.markCnt = r.markCnt - 8'h01;
    // Length of the current marker, kept for the width check [R14]
    next_r.syncLen = sync ? r.syncLen + 8'h01 : 8'h00;
    if (startPair && legal && r.cfg.enable)
    begin
      next_r.st       = gdpg_pkg::ST_RISE; // [R1]
      next_r.second   = 1'b0;
      next_r.phase    = 12'h000;
      next_r.spaceRun = 1'b1;
      next_r.spaceCnt = 12'h000;
      next_r.stepDiv  = 8'h00;
      // Marker opens with the shape output for 400 ns [R13] [R14] [R12]
      next_r.markCnt  = 8'(gdpg_pkg::MARK_CYC);
    end
    else if (stepTick)
    begin
      if (r.spaceRun)
      begin
        next_r.spaceCnt = r.spaceCnt + 12'h001;
        // Second pulse one spacing after the first began [R21]
        if (r.spaceCnt + 12'h001 == r.cfg.space)
        begin
          next_r.spaceRun = 1'b0;
          next_r.st       = gdpg_pkg::ST_RISE;
          next_r.second   = 1'b1;
          next_r.phase    = 12'h000;
        end
      end
      next_r.phase = (next_r.phase == r.phase) ? r.phase + 12'h001
                                               : next_r.phase;
      // Edges end at the step where the curve is within one step [R11]
      unique case (r.st)
        gdpg_pkg::ST_IDLE: next_r.phase = 12'h000;
        gdpg_pkg::ST_RISE:
          if (r.phase + 12'h001 >= r.cfg.rise)
          begin
            next_r.st    = gdpg_pkg::ST_FLAT;
            next_r.phase = 12'h000;
          end
        gdpg_pkg::ST_FLAT:
          // Top holds width minus half of each edge [R9] [R8]
          if ({1'b0, r.phase} + 13'h1 + (edgeSum >> 1)
              >= {1'b0, r.cfg.width})
          begin
            next_r.st    = gdpg_pkg::ST_FALL;
            next_r.phase = 12'h000;
          end
        gdpg_pkg::ST_FALL:
          if (r.phase + 12'h001 >= r.cfg.fall)
          begin
            next_r.st    = r.second ? gdpg_pkg::ST_IDLE : gdpg_pkg::ST_GAP;
            next_r.phase = 12'h000;
          end
        gdpg_pkg::ST_GAP:
          next_r.phase = 12'h000;
        default: next_r.st = gdpg_pkg::ST_IDLE;
      endcase
    end
    // Amplitude registered so video and RF gating share one edge [R16]
    unique case (r.st)
      gdpg_pkg::ST_RISE: next_r.amp = edgeAmp(r.phase, r.cfg.rise);
      gdpg_pkg::ST_FLAT: next_r.amp = AMP_TOP;
      gdpg_pkg::ST_FALL: next_r.amp = ~edgeAmp(r.phase, r.cfg.fall);
      default:           next_r.amp = '0;
    endcase
    // Illegal profile forces everything off until fixed [R18]
    if (!legal || !r.cfg.enable)
    begin
      next_r.st       = gdpg_pkg::ST_IDLE;
      next_r.spaceRun = 1'b0;
      next_r.amp      = '0;
      next_r.markCnt  = 8'h00;
    end
    // Registers writable in either mode at any time [R2]
    if (apbWr)
    begin
      unique case (paddr)
        gdpg_pkg::ADDR_CTRL:
        begin
          next_r.cfg.trigMode = pwdata[0];
          next_r.cfg.enable   = pwdata[1];
          if (pwdata[2])
          begin
            // Restore gaussian edges from width and re-enable [R19] [R10]
            next_r.cfg.rise   = gaussRise;
            next_r.cfg.fall   = gaussFall;
            next_r.cfg.enable = 1'b1;
          end
        end
        // Out-of-range writes are ignored and keep the old value [R3] [R4] [R5] [R6]
        gdpg_pkg::ADDR_WIDTH: next_r.cfg.width = inRange(pwdata[11:0],
          gdpg_pkg::WIDTH_MIN, gdpg_pkg::WIDTH_MAX) ? pwdata[11:0]
          : r.cfg.width;
        gdpg_pkg::ADDR_RISE: next_r.cfg.rise = inRange(pwdata[11:0],
          gdpg_pkg::RISE_MIN, gdpg_pkg::RISE_MAX) ? pwdata[11:0]
          : r.cfg.rise;
        gdpg_pkg::ADDR_FALL: next_r.cfg.fall = inRange(pwdata[11:0],
          gdpg_pkg::FALL_MIN, gdpg_pkg::FALL_MAX) ? pwdata[11:0]
          : r.cfg.fall;
        gdpg_pkg::ADDR_SPACE: next_r.cfg.space = inRange(pwdata[11:0],
          gdpg_pkg::SPACE_MIN, gdpg_pkg::SPACE_MAX) ? pwdata[11:0]
          : r.cfg.space;
        gdpg_pkg::ADDR_RATE:
          if (pwdata[15:0] >= gdpg_pkg::RATE_MIN
              && pwdata[15:0] <= gdpg_pkg::RATE_MAX)
            next_r.cfg.rate = pwdata[15:0];
        default: next_r.cfg = r.cfg;
      endcase
    end
    // Read data captured in the setup cycle, shown in the access cycle
    unique case (paddr)
      gdpg_pkg::ADDR_CTRL:   next_r.rdata = {30'h0, r.cfg.enable,
                                             r.cfg.trigMode};
      gdpg_pkg::ADDR_WIDTH:  next_r.rdata = {20'h0, r.cfg.width};
      gdpg_pkg::ADDR_RISE:   next_r.rdata = {20'h0, r.cfg.rise};
      gdpg_pkg::ADDR_FALL:   next_r.rdata = {20'h0, r.cfg.fall};
      gdpg_pkg::ADDR_SPACE:  next_r.rdata = {20'h0, r.cfg.space};
      gdpg_pkg::ADDR_RATE:   next_r.rdata = {16'h0, r.cfg.rate};
      gdpg_pkg::ADDR_STATUS: next_r.rdata = {26'h0, r.st, !legal};
      default:               next_r.rdata = 32'h0;
    endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      r            <= '0;
      r.st         <= gdpg_pkg::ST_IDLE;
      r.cfg.enable <= 1'b1;
      r.cfg.width  <= gdpg_pkg::WIDTH_RST;
      r.cfg.rise   <= gdpg_pkg::RISE_RST;
      r.cfg.fall   <= gdpg_pkg::FALL_RST;
      r.cfg.space  <= gdpg_pkg::SPACE_RST;
      r.cfg.rate   <= gdpg_pkg::RATE_RST;
    end
    else
      r <= next_r;
  end

  logic mapped;
  assign mapped  = (paddr <= gdpg_pkg::ADDR_STATUS) && (paddr[1:0] == 2'b00);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata  = r.rdata;
  assign video   = r.amp;
  assign sync    = (r.markCnt != 8'h00);
  assign profileErr = !legal;

  a_mark_width: assert property (@(posedge clk) disable iff (!rstn)
    $fell(sync) |-> r.syncLen == 8'(gdpg_pkg::MARK_CYC)) // [R14]
    else $error("marker width not 400 ns");
  a_illegal_off: assert property (@(posedge clk) disable iff (!rstn)
    !legal |=> (video == '0) && !sync) // [R18]
    else $error("outputs live on illegal profile");
  a_mark_start: assert property (@(posedge clk) disable iff (!rstn)
    $rose(sync) |-> r.st == gdpg_pkg::ST_RISE && !r.second) // [R13]
    else $error("marker not at first pulse start");
  a_gauss_set: assert property (@(posedge clk) disable iff (!rstn)
    apbWr && paddr == gdpg_pkg::ADDR_CTRL && pwdata[2]
    |=> r.cfg.enable && r.cfg.rise + r.cfg.fall <= r.cfg.width) // [R19]
    else $error("restore gaussian failed");
  a_trig_once: assert property (@(posedge clk) disable iff (!rstn)
    r.cfg.trigMode && !trigEdge && r.st == gdpg_pkg::ST_IDLE
    && !r.spaceRun |=> !$rose(sync)) // [R20]
    else $error("pair without trigger");
  a_width_range: assert property (@(posedge clk) disable iff (!rstn)
    r.cfg.width >= gdpg_pkg::WIDTH_MIN
    && r.cfg.width <= gdpg_pkg::WIDTH_MAX) // [R3]
    else $error("width out of range");
  a_space_range: assert property (@(posedge clk) disable iff (!rstn)
    r.cfg.space >= gdpg_pkg::SPACE_MIN
    && r.cfg.space <= gdpg_pkg::SPACE_MAX) // [R6]
    else $error("spacing out of range");
  a_err_flag: assert property (@(posedge clk) disable iff (!rstn)
    profileErr == (r.cfg.rise + r.cfg.fall > r.cfg.width
    || pulseSum > {2'b00, r.cfg.space})) // [R18]
    else $error("error flag mismatch");
endmodule
`default_nettype wire

// *** gdpg_trig_src.sv ***
// External trigger source model: clean logic-level pulses on request
`default_nettype none
module gdpg_trig_src #(
  parameter int HIGH_CYC = 20
) (
  // Clock and request
  input  wire logic clk,
  input  wire logic fire,
  // Trigger line
  output var  logic trigIn
);
  timeunit 1ns;
  timeprecision 1ns;
  int left = 0;
  // Driven low between pulses, so an idle line never floats
  always @(posedge clk)
  begin
    if (fire)
      left = HIGH_CYC;
    trigIn <= (left > 0);
    if (left > 0)
      left = left - 1;
  end
endmodule
`default_nettype wire

// *** gdpg_gen_tb.sv ***
// Self-checking testbench for the gaussian double pulse generator
`default_nettype none
module gdpg_gen_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                      clk;
  logic                      rstn;
  logic                      psel;
  logic                      penable;
  logic                      pwrite;
  logic [7:0]                paddr;
  logic [31:0]               pwdata;
  logic [31:0]               prdata;
  logic                      pready;
  logic                      pslverr;
  logic                      trigIn;
  logic                      fire;
  logic [gdpg_pkg::AMP_W-1:0] video;
  logic                      sync;
  logic                      profileErr;
  logic                      syncQ;
  logic                      vidNz;
  logic [31:0]               rd;
  logic                      err;
  int                        miscompares = 0;
  int                        samples_checked = 0;
  int                        seed = 32'hc02a;
  int                        model [7];
  int                        lo [7];
  int                        hi [7];
  int                        cyc = 0;
  int                        syncRun = 0;
  int                        vidMax = 0;
  int                        syncT [$];
  int                        vidT [$];
  int                        w;

  gdpg_gen u_gdpg_gen (
    .clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .trigIn(trigIn),
    .video(video), .sync(sync), .profileErr(profileErr)
  );
  gdpg_trig_src u_gdpg_trig_src (.clk(clk), .fire(fire), .trigIn(trigIn));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Output monitor: edge times in cycles, sync run length, peak amplitude
  always @(posedge clk)
  begin
    cyc++;
    if (sync === 1'b1 && syncQ === 1'b0)
    begin
      syncT.push_back(cyc);
      syncRun = 0;
    end
    if (sync === 1'b1)
      syncRun++;
    if (video !== '0 && vidNz === 1'b0)
      vidT.push_back(cyc);
    if (video > vidMax)
      vidMax = video;
    syncQ = sync;
    vidNz = (video !== '0);
  end

  task end_of_test;
    if (miscompares == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; the idle edge after it keeps drives one per step
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // Model write: out-of-range values keep the old setting
  task mw(input logic [7:0] a, input logic [31:0] d);
    int i;
    i = a / 4;
    if (i >= 1 && i <= 5 && int'(d) >= lo[i] && int'(d) <= hi[i])
      model[i] = d;
    if (i == 0)
      model[0] = {d[2] | d[1], d[0]};
    // Restored edges: gaussian ratio, capped so rise plus fall fits width
    if (i == 0 && d[2])
    begin
      model[3] = (model[1] / 2 < lo[3]) ? lo[3] : model[1] / 2;
      model[2] = model[1] * 164 / 256;
      if (model[2] > model[1] - model[3])
        model[2] = model[1] - model[3];
    end
    apb(1'b1, a, d);
  endtask

  task rdall;
    for (int a = 4; a <= 20; a += 4)
    begin
      apb(1'b0, a[7:0], 32'h0);
      chk(rd, model[a/4]);
    end
  endtask

  function automatic logic eerr;
    return model[1] < model[2] + model[3] ||
           model[1] + model[2] + model[3] > model[4];
  endfunction

  task clr;
    syncT.delete();
    vidT.delete();
    vidMax = 0;
  endtask

  task shot;
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
  endtask

  initial
  begin
    repeat (100000) @(posedge clk);
    miscompares++;
    end_of_test();
  end

  initial
  begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    fire = 1'b0;
    lo = '{0, gdpg_pkg::WIDTH_MIN, gdpg_pkg::RISE_MIN, gdpg_pkg::FALL_MIN,
           gdpg_pkg::SPACE_MIN, gdpg_pkg::RATE_MIN, 0};
    hi = '{0, gdpg_pkg::WIDTH_MAX, gdpg_pkg::RISE_MAX, gdpg_pkg::FALL_MAX,
           gdpg_pkg::SPACE_MAX, gdpg_pkg::RATE_MAX, 0};
    model = '{0, gdpg_pkg::WIDTH_RST, gdpg_pkg::RISE_RST, gdpg_pkg::FALL_RST,
              gdpg_pkg::SPACE_RST, gdpg_pkg::RATE_RST, 0};
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rdall();
    apb(1'b0, 8'h1c, 32'h0);
    chk(err, 1'b1);
    apb(1'b0, 8'h05, 32'h0);
    chk(err, 1'b1);
    apb(1'b0, gdpg_pkg::ADDR_WIDTH, 32'h0);
    chk(err, 1'b0);
    // Just outside one limit of each register, then the spacing upper limit itself
    mw(gdpg_pkg::ADDR_WIDTH, gdpg_pkg::WIDTH_MIN - 1);
    mw(gdpg_pkg::ADDR_RISE, gdpg_pkg::RISE_MAX + 1);
    mw(gdpg_pkg::ADDR_FALL, gdpg_pkg::FALL_MIN - 1);
    mw(gdpg_pkg::ADDR_SPACE, gdpg_pkg::SPACE_MAX + 1);
    mw(gdpg_pkg::ADDR_RATE, gdpg_pkg::RATE_MIN - 1);
    mw(gdpg_pkg::ADDR_SPACE, gdpg_pkg::SPACE_MAX);
    rdall();
    mw(gdpg_pkg::ADDR_SPACE, gdpg_pkg::SPACE_RST);
    w = gdpg_pkg::WIDTH_MIN + $unsigned($random(seed)) % 111;
    mw(gdpg_pkg::ADDR_WIDTH, w);
    mw(gdpg_pkg::ADDR_CTRL, 32'h6);
    rdall();
    chk(profileErr, eerr());
    // Illegal profile: outputs must stay dead for a whole period
    mw(gdpg_pkg::ADDR_RISE, gdpg_pkg::RISE_MAX);
    mw(gdpg_pkg::ADDR_FALL, gdpg_pkg::FALL_MAX);
    chk(profileErr, 1'b1);
    apb(1'b0, gdpg_pkg::ADDR_STATUS, 32'h0);
    chk(rd[0], 1'b1);
    clr();
    repeat (17000) @(posedge clk);
    chk(vidMax, 0);
    chk(syncT.size(), 0);
    // Triggered but disabled first, so no stray pair starts once legal
    mw(gdpg_pkg::ADDR_CTRL, 32'h1);
    mw(gdpg_pkg::ADDR_WIDTH, gdpg_pkg::WIDTH_MAX);
    mw(gdpg_pkg::ADDR_RISE, gdpg_pkg::RISE_MIN);
    mw(gdpg_pkg::ADDR_FALL, gdpg_pkg::FALL_MIN);
    chk(profileErr, eerr());
    clr();
    shot();
    repeat (300) @(posedge clk);
    chk(syncT.size(), 0);
    chk(vidMax, 0);
    // Triggered: a second trigger inside the pair must not start another
    mw(gdpg_pkg::ADDR_CTRL, 32'h3);
    apb(1'b0, gdpg_pkg::ADDR_CTRL, 32'h0);
    chk(rd, model[0]);
    clr();
    shot();
    repeat (300) @(posedge clk);
    shot();
    repeat (3000) @(posedge clk);
    chk(syncT.size(), 1);
    chk(syncRun, gdpg_pkg::MARK_CYC);
    chk(vidT.size(), 2);
    if (vidT.size() == 2)
      chk(vidT[1] - vidT[0], model[4] * gdpg_pkg::STEP_CYC);
    chk(vidMax >= 254, 1'b1);
    // Continuous: pairs one repetition period apart
    clr();
    mw(gdpg_pkg::ADDR_CTRL, 32'h2);
    for (int i = 0; i < 60000 && syncT.size() < 3; i++)
      @(posedge clk);
    chk(syncT.size() >= 3, 1'b1);
    if (syncT.size() >= 3)
      chk(syncT[2] - syncT[1], (gdpg_pkg::STEPS_PER_SEC / model[5]) *
          gdpg_pkg::STEP_CYC);
    end_of_test();
  end
endmodule
`default_nettype wire
